//--- include/imac_params.svh
`ifndef IMAC_PARAMS_SVH
`define IMAC_PARAMS_SVH

// ============================================================
// Operation codes on the request port.
`define IMAC_OP_W 3
`define IMAC_OP_LOW 3'h0
`define IMAC_OP_ADD 3'h1
`define IMAC_OP_SUB 3'h2
`define IMAC_OP_WIDE 3'h3
`define IMAC_OP_WDBL 3'h4
`define IMAC_OP_WACC 3'h5
`define IMAC_OP_HMAC 3'h6
`define IMAC_OP_WHMAC 3'h7

// ============================================================
// Condition codes and flag vector layout (n, z, c, v).
`define IMAC_COND_W 4
`define IMAC_COND_AL 4'he
`define IMAC_FLAG_N 3
`define IMAC_FLAG_Z 2
`define IMAC_FLAG_C 1
`define IMAC_FLAG_V 0
`define IMAC_FLAGS_RST 4'h0

// ============================================================
// Register numbers and widths.
`define IMAC_REG_W 4
`define IMAC_REG_SP 4'hd
`define IMAC_REG_PC 4'hf
`define IMAC_WORD_W 32
`define IMAC_HALF_W 16

`endif

//--- include/imac_pkg.sv
package imac_pkg;
  typedef logic [31:0] imac_word_t;
  typedef logic [3:0] imac_reg_t;
  typedef enum logic [1:0] {
    IMAC_IDLE,
    IMAC_DONE
  } imac_state_t;
endpackage

//--- include/imac_res_if.sv
`timescale 1ns/100ps
// ============================================================
// Result bundle between the arithmetic core and the top.
interface imac_res_if;
  logic [31:0] lo;
  logic [31:0] hi;
  logic sat;
  modport core (output lo, output hi, output sat);
  modport top (input lo, input hi, input sat);
endinterface

//--- hdl/imac_cond.sv
`timescale 1ns/100ps
`include "imac_params.svh"
// ============================================================
// Condition evaluation against the current flags.
module imac_cond (
  // Inputs
  input wire logic [3:0] cond,
  input wire logic [3:0] flags,
  // Result
  output logic pass
);
  wire n = flags[`IMAC_FLAG_N];
  wire z = flags[`IMAC_FLAG_Z];
  wire c = flags[`IMAC_FLAG_C];
  wire v = flags[`IMAC_FLAG_V];
  wire base;
  assign base = (cond[3:1] == 3'h0) ? z :
                (cond[3:1] == 3'h1) ? c :
                (cond[3:1] == 3'h2) ? n :
                (cond[3:1] == 3'h3) ? v :
                (cond[3:1] == 3'h4) ? (c & ~z) :
                (cond[3:1] == 3'h5) ? (n == v) :
                (cond[3:1] == 3'h6) ? (~z & (n == v)) : 1'b1;
  // Code 0xf behaves as always, like 0xe.
  assign pass = (cond[3:1] == 3'h7) ? 1'b1 : (base ^ cond[0]);
endmodule

//--- hdl/imac_core.sv
`timescale 1ns/100ps
`include "imac_params.svh"
// ============================================================
// Combinational arithmetic for all operations.
module imac_core (
  // Request
  input wire logic [2:0] op,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  input wire logic [31:0] acc,
  input wire logic [31:0] dlo,
  input wire logic [31:0] dhi,
  input wire logic sel_a_top,
  input wire logic sel_b_top,
  // Result
  imac_res_if.core res
);
  function automatic logic [15:0] pick_half(input logic [31:0] w, input logic top);
    pick_half = top ? w[31:16] : w[15:0];
  endfunction

  // One unsigned product; its low word is sign-independent.
  wire [63:0] uprod = {32'h0, opa} * {32'h0, opb};
  wire [31:0] low_mul = uprod[31:0];
  wire [31:0] low_add = low_mul + acc;
  wire [31:0] low_sub = acc - low_mul;
  wire [63:0] dbl_sum = uprod + {32'h0, dhi} + {32'h0, dlo};
  wire [63:0] acc_sum = uprod + {dhi, dlo};

  wire signed [15:0] ha = pick_half(opa, sel_a_top);
  wire signed [15:0] hb = pick_half(opb, sel_b_top);
  wire signed [31:0] hprod = ha * hb;
  wire signed [47:0] wprod = $signed(opa) * hb;
  wire signed [31:0] wtop = wprod[47:16];
  wire signed [31:0] sacc = $signed(acc);
  wire signed [32:0] hsum = {hprod[31], hprod} + {sacc[31], sacc};
  wire signed [32:0] wsum = {wtop[31], wtop} + {sacc[31], sacc};
  wire [32:0] msum = (op == `IMAC_OP_HMAC) ? hsum : wsum;
  wire ovf = msum[32] ^ msum[31];

  assign res.lo = (op == `IMAC_OP_LOW) ? low_mul :
                  (op == `IMAC_OP_ADD) ? low_add :
                  (op == `IMAC_OP_SUB) ? low_sub :
                  (op == `IMAC_OP_WIDE) ? uprod[31:0] :
                  (op == `IMAC_OP_WDBL) ? dbl_sum[31:0] :
                  (op == `IMAC_OP_WACC) ? acc_sum[31:0] : msum[31:0];
  assign res.hi = (op == `IMAC_OP_WIDE) ? uprod[63:32] :
                  (op == `IMAC_OP_WDBL) ? dbl_sum[63:32] :
                  (op == `IMAC_OP_WACC) ? acc_sum[63:32] : 32'h0;
  assign res.sat = ((op == `IMAC_OP_HMAC) || (op == `IMAC_OP_WHMAC)) & ovf;
endmodule

//--- hdl/imac_unit.sv
`timescale 1ns/100ps
`include "imac_params.svh"
// Contract
// - Low-word multiply keeps low 32 bits
// - Multiply-add writes low 32 bits
// - Accumulator minus product, low 32 bits
// - Low results independent of operand signedness
// - Flag option sets N and Z on the low-word multiply only
// - Flag-updating multiply keeps C and V
// - Omitted destination writes first operand register
// - Unsigned 64-bit product into register pair
// - Double add of both halves
// - 64-bit accumulate into register pair
// - Wide multiplies leave flags alone
// - Halfword select bottom or top
// - Word times selected second halfword
// - Optional predicate gates execution
// - Halfword product plus accumulator
// - Accumulator plus top 32 of 48
// - Accumulate overflow sets sticky saturation
module imac_unit (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request from the decoder
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [3:0] req_cond,
  input wire logic req_set_flags,
  input wire logic req_dest_omit,
  input wire logic req_first_top,
  input wire logic req_second_top,
  input wire logic [3:0] dest_reg,
  input wire logic [3:0] first_operand_reg,
  input wire logic [3:0] dest_low_word,
  input wire logic [3:0] dest_high_word,
  // Operand values from the register file
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic [31:0] accumulator,
  input wire logic [31:0] dest_low_val,
  input wire logic [31:0] dest_high_val,
  // Flag writes from elsewhere in the core
  input wire logic flags_wr,
  input wire logic [3:0] flags_wdata,
  input wire logic sat_clr,
  // Results to the register file
  output logic wr0_en,
  output logic [3:0] wr0_reg,
  output logic [31:0] wr0_data,
  output logic wr1_en,
  output logic [3:0] wr1_reg,
  output logic [31:0] wr1_data,
  // Flags
  output logic [3:0] flags,
  output logic saturation_flag,
  output logic busy
);
  // ============================================================
  // Arithmetic and predicate.
  imac_res_if res_b ();
  logic cond_ok;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic sat_q;
  logic sat_d;
  logic wr0_en_q;
  logic [3:0] wr0_reg_q;
  logic [31:0] wr0_data_q;
  logic wr1_en_q;
  logic [3:0] wr1_reg_q;
  logic [31:0] wr1_data_q;
  imac_pkg::imac_state_t state_q;
  imac_pkg::imac_state_t state_d;
  logic busy_q;

  imac_core u_core (
    .op(req_op),
    .opa(first_operand),
    .opb(second_operand),
    .acc(accumulator),
    .dlo(dest_low_val),
    .dhi(dest_high_val),
    .sel_a_top(req_first_top),
    .sel_b_top(req_second_top),
    .res(res_b.core)
  );

  imac_cond u_cond (
    .cond(req_cond),
    .flags(flags_q),
    .pass(cond_ok)
  );

  // ============================================================
  // Decode, all as named wires.

  wire is_wide = (req_op == `IMAC_OP_WIDE) || (req_op == `IMAC_OP_WDBL) ||
                 (req_op == `IMAC_OP_WACC);
  wire is_sat_op = (req_op == `IMAC_OP_HMAC) || (req_op == `IMAC_OP_WHMAC);
  // The issuer keeps the predicate off flag-setting multiplies, so the
  // condition is honoured as given in every case.
  wire exec = req_valid & cond_ok;
  wire set_nz = exec & req_set_flags & (req_op == `IMAC_OP_LOW);
  // Register numbers are used as given; stack pointer and program
  // counter are never named by the issuer.
  wire [3:0] dst = req_dest_omit ? first_operand_reg : dest_reg;
  wire [3:0] dst0 = is_wide ? dest_low_word : dst;

  wire res_n = res_b.lo[31];
  wire res_z = (res_b.lo == 32'h0);
  // Carry and overflow are carried over untouched.
  wire [3:0] flag_mul = {res_n, res_z, flags_q[`IMAC_FLAG_C], flags_q[`IMAC_FLAG_V]};
  // Wide and other operations leave the flags alone.
  assign flags_d = set_nz ? flag_mul : (flags_wr ? flags_wdata : flags_q);
  // A new overflow wins over a clear in the same cycle.
  assign sat_d = (exec & is_sat_op & res_b.sat) ? 1'b1 :
                 (sat_clr ? 1'b0 : sat_q);

  // ============================================================
  // State.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_q <= `IMAC_FLAGS_RST;
      sat_q <= 1'b0;
    end else begin
      flags_q <= flags_d;
      sat_q <= sat_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr0_en_q <= 1'b0;
      wr1_en_q <= 1'b0;
    end else begin
      wr0_en_q <= exec;
      wr1_en_q <= exec & is_wide;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr0_reg_q <= 4'h0;
      wr0_data_q <= 32'h0;
      wr1_reg_q <= 4'h0;
      wr1_data_q <= 32'h0;
    end else begin
      wr0_reg_q <= dst0;
      wr0_data_q <= res_b.lo;
      wr1_reg_q <= dest_high_word;
      wr1_data_q <= res_b.hi;
    end
  end

  // Result register stage tracker; one result per cycle.
  always_comb begin
    case (state_q)
      imac_pkg::IMAC_IDLE: state_d = exec ? imac_pkg::IMAC_DONE : imac_pkg::IMAC_IDLE;
      imac_pkg::IMAC_DONE: state_d = exec ? imac_pkg::IMAC_DONE : imac_pkg::IMAC_IDLE;
      default: state_d = imac_pkg::IMAC_IDLE;
    endcase
  end

  // Busy is registered beside the state so the output comes from a flop.
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= imac_pkg::IMAC_IDLE;
      busy_q <= 1'b0;
    end else begin
      state_q <= state_d;
      busy_q <= (state_d == imac_pkg::IMAC_DONE);
    end
  end

  assign wr0_en = wr0_en_q;
  assign wr0_reg = wr0_reg_q;
  assign wr0_data = wr0_data_q;
  assign wr1_en = wr1_en_q;
  assign wr1_reg = wr1_reg_q;
  assign wr1_data = wr1_data_q;
  assign flags = flags_q;
  assign saturation_flag = sat_q;
  assign busy = busy_q;
endmodule

//--- test/imac_unit_sva.sv
`timescale 1ns/100ps
`include "imac_params.svh"
module imac_unit_sva (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Request
  input wire logic req_valid,
  input wire logic [2:0] req_op,
  input wire logic [3:0] req_cond,
  input wire logic req_set_flags,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic [31:0] accumulator,
  input wire logic flags_wr,
  // Results
  input wire logic wr0_en,
  input wire logic [31:0] wr0_data,
  input wire logic wr1_en,
  input wire logic [31:0] wr1_data,
  input wire logic [3:0] flags
);
  logic [63:0] prod_q;
  logic [31:0] acc_q;
  // Captured operands let each check see the values of the taking edge.
  always_ff @(posedge sys_clk) begin
    prod_q <= {32'h0, first_operand} * {32'h0, second_operand};
    acc_q <= accumulator;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_op(logic [2:0] o);
    req_valid && req_cond == `IMAC_COND_AL && req_op == o;
  endsequence
  sequence s_nz;
    s_op(`IMAC_OP_LOW) ##0 req_set_flags;
  endsequence
  a_low_word_prod: assert property (s_op(`IMAC_OP_LOW) |=>
    wr0_en && wr0_data == prod_q[31:0]) else $error("low product wrong");
  a_add_low_word: assert property (s_op(`IMAC_OP_ADD) |=>
    wr0_en && wr0_data == prod_q[31:0] + acc_q) else $error("add result wrong");
  a_sub_low_word: assert property (s_op(`IMAC_OP_SUB) |=>
    wr0_en && wr0_data == acc_q - prod_q[31:0]) else $error("sub result wrong");
  a_wide_pair_out: assert property (s_op(`IMAC_OP_WIDE) |=>
    wr1_en && {wr1_data, wr0_data} == prod_q) else $error("wide pair wrong");
  a_nz_from_result: assert property (s_nz |=>
    flags[3] == wr0_data[31] && flags[2] == (wr0_data == 32'h0)) else $error("nz wrong");
  a_cv_kept: assert property (s_nz |=> $stable(flags[1:0]))
    else $error("cv changed");
  a_wide_flags_kept: assert property (req_valid && !flags_wr && req_op inside
    {`IMAC_OP_WIDE, `IMAC_OP_WDBL, `IMAC_OP_WACC} |=> $stable(flags)) else $error("flags moved");
  a_false_no_write: assert property (req_valid && req_cond == 4'h0 && !flags[2]
    |=> !wr0_en && !wr1_en) else $error("write on false predicate");
endmodule
bind imac_unit imac_unit_sva u_sva (.*);

//--- test/imac_rf_model.sv
`timescale 1ns/100ps
// ============================================================
// Register file: takes the unit's writes and feeds the pair back.
module imac_rf_model (
  // Clock
  input wire logic sys_clk,
  // Writes
  input wire logic wr0_en,
  input wire logic [3:0] wr0_reg,
  input wire logic [31:0] wr0_data,
  input wire logic wr1_en,
  input wire logic [3:0] wr1_reg,
  input wire logic [31:0] wr1_data,
  // Reads
  input wire logic [3:0] rd0_reg,
  input wire logic [3:0] rd1_reg,
  output logic [31:0] rd0_val,
  output logic [31:0] rd1_val
);
  logic [31:0] rf_q [16];
  initial for (int i = 0; i < 16; i++) rf_q[i] = 32'h9e3779b9 * i;
  // Both ports land on one edge; the issuer never names one register twice.
  always @(posedge sys_clk) begin
    if (wr0_en) rf_q[wr0_reg] <= wr0_data;
    if (wr1_en) rf_q[wr1_reg] <= wr1_data;
  end
  assign rd0_val = rf_q[rd0_reg];
  assign rd1_val = rf_q[rd1_reg];
endmodule

//--- test/tb_imac_unit.sv
`timescale 1ns/100ps
`include "imac_params.svh"
module tb_imac_unit;
  typedef struct packed {
    logic [3:0] r0; logic [31:0] d0; logic w; logic [3:0] r1;
    logic [31:0] d1; logic [3:0] f; logic s;
  } imac_note_t;
  logic sys_clk = 1'b0, reset_n = 1'b0, req_valid = 1'b0, req_set_flags = 1'b0;
  logic req_dest_omit = 1'b0, req_first_top = 1'b0, req_second_top = 1'b0, es = 1'b0;
  logic flags_wr = 1'b0, sat_clr = 1'b0, wr0_en, wr1_en, saturation_flag, busy;
  logic [2:0] req_op = 3'h0;
  logic [3:0] req_cond = 4'he, dest_reg = 4'h0, first_operand_reg = 4'h0, flags_wdata = 4'h0;
  logic [3:0] dest_low_word = 4'h0, dest_high_word = 4'h1, wr0_reg, wr1_reg, flags, ef = 4'h0;
  logic [31:0] first_operand = 32'h0, second_operand = 32'h0, accumulator = 32'h0;
  logic [31:0] dest_low_val, dest_high_val, wr0_data, wr1_data, lfsr_q = 32'h133db;
  int num_errors = 0, n_compared = 0;
  imac_note_t q[$];
  imac_note_t nt;
  always #25 sys_clk = ~sys_clk;
  imac_unit dut (.*);
  imac_rf_model u_rf (.sys_clk(sys_clk), .wr0_en(wr0_en), .wr0_reg(wr0_reg),
    .wr0_data(wr0_data), .wr1_en(wr1_en), .wr1_reg(wr1_reg), .wr1_data(wr1_data),
    .rd0_reg(dest_low_word), .rd1_reg(dest_high_word), .rd0_val(dest_low_val),
    .rd1_val(dest_high_val));
  function automatic logic [31:0] rnd();
    repeat (32) lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction
  // Predicate outcome for flags ordered n, z, c, v.
  function automatic logic pred(input logic [3:0] c, input logic [3:0] f);
    case (c[3:1])
      3'h0: pred = f[2];
      3'h1: pred = f[1];
      3'h2: pred = f[3];
      3'h3: pred = f[0];
      3'h4: pred = f[1] & ~f[2];
      3'h5: pred = f[3] == f[0];
      3'h6: pred = ~f[2] & (f[3] == f[0]);
      default: pred = 1'b1;
    endcase
    if (c[3:1] != 3'h7) pred = pred ^ c[0];
  endfunction
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic req(input logic [2:0] op, input logic [3:0] c, input logic ok, input logic hot);
    logic [63:0] p;
    logic [47:0] w;
    logic [31:0] r, m;
    logic [15:0] ha, hb;
    imac_note_t n;
    r = rnd();
    {req_valid, req_op, req_cond} = {1'b1, op, c};
    // Flag-setting multiplies never carry a predicate.
    {req_set_flags, req_dest_omit, req_first_top, req_second_top} =
      {r[3] & (c == `IMAC_COND_AL), r[2:0]};
    // Low registers only, a distinct pair, never the stack pointer or counter.
    {dest_reg, first_operand_reg, dest_low_word, dest_high_word} =
      {1'b0, r[6:4], 1'b0, r[10:8], 1'b0, r[14:12], 1'b0, r[14:13], ~r[12]};
    {first_operand, second_operand, accumulator} = hot ?
      {{2{32'h7fff7fff}}, 32'h7fffffff} : {rnd(), rnd(), rnd()};
    #1;
    p = {32'h0, first_operand} * {32'h0, second_operand};
    ha = req_first_top ? first_operand[31:16] : first_operand[15:0];
    hb = req_second_top ? second_operand[31:16] : second_operand[15:0];
    w = {{16{first_operand[31]}}, first_operand} * {{32{hb[15]}}, hb};
    m = {{16{ha[15]}}, ha} * {{16{hb[15]}}, hb};
    n = '0;
    n.r0 = req_dest_omit ? first_operand_reg : dest_reg;
    case (op)
      `IMAC_OP_LOW: n.d0 = p[31:0];
      `IMAC_OP_ADD: n.d0 = p[31:0] + accumulator;
      `IMAC_OP_SUB: n.d0 = accumulator - p[31:0];
      `IMAC_OP_WIDE: {n.d1, n.d0} = p;
      `IMAC_OP_WDBL: {n.d1, n.d0} = p + dest_low_val + dest_high_val;
      `IMAC_OP_WACC: {n.d1, n.d0} = p + {dest_high_val, dest_low_val};
      `IMAC_OP_HMAC: n.d0 = m + accumulator;
      default: m = w[47:16];
    endcase
    if (op == `IMAC_OP_WHMAC) n.d0 = m + accumulator;
    if (op >= `IMAC_OP_HMAC) es |= ok && m[31] == accumulator[31] && n.d0[31] != m[31];
    if (ok && op == `IMAC_OP_LOW && req_set_flags) ef[3:2] = {n.d0[31], n.d0 == 32'h0};
    n.w = op inside {`IMAC_OP_WIDE, `IMAC_OP_WDBL, `IMAC_OP_WACC};
    if (n.w) {n.r0, n.r1} = {dest_low_word, dest_high_word};
    {n.f, n.s} = {ef, es};
    if (ok) q.push_back(n);
    @(posedge sys_clk);
    #1;
  endtask
  always @(posedge sys_clk) begin
    if (reset_n && wr0_en === 1'b1) begin
      if (q.size() == 0) begin
        check(1, 0);
      end else begin
        nt = q.pop_front();
        check({wr0_reg, wr0_data}, {nt.r0, nt.d0});
        check(wr1_en, nt.w);
        if (nt.w) check({wr1_reg, wr1_data}, {nt.r1, nt.d1});
        check({flags, saturation_flag}, {nt.f, nt.s});
        check(busy, 1'b1);
      end
    end else if (reset_n) begin
      check({busy, wr1_en}, 2'b00);
    end
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    #1;
    {reset_n, flags_wr, flags_wdata, ef} = {1'b1, 1'b1, 4'h4, 4'h4};
    @(posedge sys_clk);
    #1;
    flags_wr = 1'b0;
    req(`IMAC_OP_ADD, 4'h0, 1'b1, 1'b0);
    // Carry and overflow set, so a later flag update must keep them.
    {req_valid, flags_wr, flags_wdata, ef} = {1'b0, 1'b1, 4'h3, 4'h3};
    @(posedge sys_clk);
    #1;
    flags_wr = 1'b0;
    req(`IMAC_OP_WIDE, 4'h0, 1'b0, 1'b0);
    for (int i = 0; i < 48; i++) req(i[2:0], `IMAC_COND_AL, 1'b1, i == 14);
    // Every predicate code against the flags the unit now holds.
    for (int i = 0; i < 16; i++) req(i[2:0], i[3:0], pred(i[3:0], ef), 1'b0);
    {req_valid, sat_clr, es} = 3'b010;
    @(posedge sys_clk);
    #1;
    sat_clr = 1'b0;
    req(`IMAC_OP_LOW, `IMAC_COND_AL, 1'b1, 1'b0);
    req_valid = 1'b0;
    for (int k = 0; k < 10 && q.size() > 0; k++) @(posedge sys_clk);
    check(q.size(), 0);
    wrap_up();
  end
endmodule
